// ===== tmz_clk_sel.sv
`timescale 1ns/1ps
`include "tmz_map.svh"

module tmz_clk_sel (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Sources
    input wire tmz_pkg::tmz_src_s src,
    input wire logic instr_en,
    input wire tmz_pkg::tmz_src_e sel,
    // Rising edge of selected source
    output logic rise
);
    import tmz_pkg::*;

    tmz_src_s sync1; // First stage, read only by sync2
    tmz_src_s sync2; // Second stage
    logic lvl; // Selected level one cycle ago
    logic cur; // Selected level now

    // Two flops on every asynchronous source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= src;
            sync2 <= sync1;
        end
    end

    // Source mux
    always_comb begin
        case (sel)
            TMZ_SRC_PIN: cur = sync2.input_pin; // [RULE7]
            TMZ_SRC_PIN_INV: cur = ~sync2.input_pin;
            TMZ_SRC_INSTR: cur = 1'b0;
            TMZ_SRC_HFO: cur = sync2.high_freq_osc;
            TMZ_SRC_LFO: cur = sync2.low_freq_osc;
            TMZ_SRC_MFO: cur = sync2.mid_freq_osc;
            TMZ_SRC_SECONDARY_OSC: cur = sync2.secondary_osc;
            TMZ_SRC_LC1: cur = sync2.logic_cell_one_output;
            default: cur = 1'b0;
        endcase
    end

    // Edge detect; a reselect may give one stray edge, which reaches the prescaler after the write has cleared it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl <= 1'b0;
            rise <= 1'b0;
        end else begin
            lvl <= cur;
            rise <= (sel == TMZ_SRC_INSTR) ? instr_en : (cur & ~lvl); // [RULE7]
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_instr_route: assert property (sel == TMZ_SRC_INSTR && $stable(sel) |=> rise == $past(instr_en)) // [RULE7]
        else $error("instruction clock not routed");

endmodule // tmz_clk_sel

// ===== tmz_map.svh
`ifndef TMZ_MAP_SVH
`define TMZ_MAP_SVH

// Register indexes; byte address is four times the index
`define TMZ_IDX_LOW 11'h59C
`define TMZ_IDX_HIGH 11'h59D
`define TMZ_IDX_CTL0 11'h59E
`define TMZ_IDX_CTL1 11'h59F
`define TMZ_IDX_STAT 11'h5A0

// Main control fields
`define TMZ_CTL0_EN 7
`define TMZ_CTL0_RSV 6
`define TMZ_CTL0_OUT 5
`define TMZ_CTL0_W16 4
`define TMZ_CTL0_OPS_LSB 0

// Clock config fields
`define TMZ_CTL1_CS_LSB 5
`define TMZ_CTL1_ASYNC 4
`define TMZ_CTL1_CKPS_LSB 0

// Status fields
`define TMZ_STAT_FLAG 0
`define TMZ_STAT_IE 1

// Reset values
`define TMZ_RST_BYTE 8'h00

// Instruction clock is system clock divided by four
`define TMZ_INSTR_DIV 4
`define TMZ_INSTR_LAST 2'h3

`endif

// ===== tmz_pkg.sv
package tmz_pkg;

    // Clock source select codes
    typedef enum logic [2:0] {
        TMZ_SRC_PIN = 3'h0,
        TMZ_SRC_PIN_INV = 3'h1,
        TMZ_SRC_INSTR = 3'h2,
        TMZ_SRC_HFO = 3'h3,
        TMZ_SRC_LFO = 3'h4,
        TMZ_SRC_MFO = 3'h5,
        TMZ_SRC_SECONDARY_OSC = 3'h6,
        TMZ_SRC_LC1 = 3'h7
    } tmz_src_e;

    // External counting sources, all asynchronous
    typedef struct packed {
        logic input_pin;
        logic high_freq_osc;
        logic low_freq_osc;
        logic mid_freq_osc;
        logic secondary_osc;
        logic logic_cell_one_output;
    } tmz_src_s;

    // Stored clock configuration
    typedef struct packed {
        tmz_src_e clock_source_select;
        logic async_select_bit;
        logic [3:0] prescale_select;
    } tmz_ctl1_s;

    // Prescaler terminal count for a ratio of 2**sel
    function automatic logic [14:0] tmz_pre_mask(input logic [3:0] sel);
        tmz_pre_mask = 15'(({16'h0000, 1'b1} << sel) - 17'h0_0001);
    endfunction

endpackage

// ===== tmz_prescale.sv
`timescale 1ns/1ps

module tmz_prescale (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic clr,
    input wire logic [3:0] sel,
    // Events
    input wire logic in_pulse,
    output logic out_pulse
);
    import tmz_pkg::*;

    logic [14:0] cnt; // Hidden prescale count

    // Counts input edges, one output per 2**sel
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 15'h0000;
            out_pulse <= 1'b0;
        end else if (clr) begin
            cnt <= 15'h0000;
            out_pulse <= 1'b0;
        end else if (in_pulse && cnt >= tmz_pre_mask(sel)) begin
            cnt <= 15'h0000; // [RULE9]
            out_pulse <= 1'b1;
        end else begin
            cnt <= in_pulse ? cnt + 15'h0001 : cnt;
            out_pulse <= 1'b0;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_pre_ratio: assert property (in_pulse && !clr && cnt == tmz_pre_mask(sel) |=> out_pulse) // [RULE9]
        else $error("prescaler missed terminal count");

endmodule // tmz_prescale

// ===== tmz_timer.sv
// Chosen here: the APB register port.
`timescale 1ns/1ps
`include "tmz_map.svh"

// Function
// RULE1: Low register is 8-bit count or low byte
// RULE2: 8-bit mode: high is period, wrap to zero
// RULE3: 16-bit mode: high holds upper count byte
// RULE4: Counts only while enable bit is set
// RULE5: Width bit: 1 is 16-bit, 0 8-bit
// RULE6: Postscaler divides output events by field+1
// RULE7: Clock select picks one of eight sources
// RULE8: Async bit bypasses instruction clock sync
// RULE9: Prescaler divides clock by two to field
// RULE10: Period match clears low, reloads period buffer
// RULE11: Output toggles after postscaler on match/rollover
// RULE12: Flag set on toggle, enable requests interrupt
// RULE13: Scaler counters clear on low/control writes, reset
// RULE14: Buffered high byte gives atomic 16-bit access
// RULE15: Bit 6 reads zero; output bit read-only
module tmz_timer (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [12:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Counting sources
    input wire tmz_pkg::tmz_src_s src,
    // Timer results
    output logic timer_output,
    output logic timer_irq
);
    import tmz_pkg::*;

    // Main control fields
    logic timer_enable_bit;
    logic width_select_bit;
    logic [3:0] postscale_select;
    // Clock config
    tmz_ctl1_s clock_config_reg;
    // Count and period state
    logic [7:0] count_low_reg; // Low counter
    logic [7:0] period_high_reg; // Period, or high byte buffer
    logic [7:0] count_high; // True high byte in 16-bit mode
    logic [7:0] period_buf; // Compare copy of the period
    // Postscaler and interrupt
    logic [3:0] post_cnt;
    logic timer_irq_flag;
    logic timer_irq_enable;
    // Instruction clock divider
    logic [1:0] instr_div;
    logic instr_en;
    // Synchronous mode pending edge
    logic pend;

    // Bus decode
    logic [10:0] idx;
    logic aligned;
    logic hit_low, hit_high, hit_ctl0, hit_ctl1, hit_stat;
    logic mapped;
    logic done; // Completion edge of an access
    logic wr, rd;
    logic wr_low, wr_high, wr_ctl0, wr_ctl1, wr_stat;
    logic rd_low;
    logic [7:0] rd_byte;

    // Counting chain
    logic src_rise;
    logic pre_pulse;
    logic cnt_tick;
    logic period_hit;
    logic roll_hit;
    logic tmr_event;
    logic post_hit;
    logic scaler_clr;

    assign idx = paddr[12:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign hit_low = aligned && idx == `TMZ_IDX_LOW;
    assign hit_high = aligned && idx == `TMZ_IDX_HIGH;
    assign hit_ctl0 = aligned && idx == `TMZ_IDX_CTL0;
    assign hit_ctl1 = aligned && idx == `TMZ_IDX_CTL1;
    assign hit_stat = aligned && idx == `TMZ_IDX_STAT;
    assign mapped = hit_low | hit_high | hit_ctl0 | hit_ctl1 | hit_stat;

    // Side effects happen at the edge where the master sees pready
    assign done = psel & penable & pready;
    assign wr = done & pwrite & mapped;
    assign rd = done & ~pwrite & mapped;
    assign wr_low = wr & hit_low;
    assign wr_high = wr & hit_high;
    assign wr_ctl0 = wr & hit_ctl0;
    assign wr_ctl1 = wr & hit_ctl1;
    assign wr_stat = wr & hit_stat;
    assign rd_low = rd & hit_low;

    // Read mux
    always_comb begin
        rd_byte = 8'h00;
        if (hit_low) begin
            rd_byte = count_low_reg;
        end else if (hit_high) begin
            rd_byte = period_high_reg; // [RULE14]
        end else if (hit_ctl0) begin
            // Bit 6 always zero, output bit shows the live level
            rd_byte = {timer_enable_bit, 1'b0, timer_output, width_select_bit, postscale_select}; // [RULE15]
        end else if (hit_ctl1) begin
            rd_byte = clock_config_reg;
        end else if (hit_stat) begin
            rd_byte = {6'h00, timer_irq_enable, timer_irq_flag};
        end
    end

    // One wait state so every bus output comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
            if (psel & penable & ~pready) begin
                prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
                pslverr <= ~mapped;
            end else begin
                prdata <= 32'h0000_0000;
                pslverr <= 1'b0;
            end
        end
    end

    // Main control register; bits 6 and 5 ignore writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_enable_bit <= 1'b0;
            width_select_bit <= 1'b0;
            postscale_select <= 4'h0;
        end else if (wr_ctl0) begin
            timer_enable_bit <= pwdata[`TMZ_CTL0_EN]; // [RULE4]
            width_select_bit <= pwdata[`TMZ_CTL0_W16]; // [RULE5]
            postscale_select <= pwdata[`TMZ_CTL0_OPS_LSB +: 4]; // [RULE15]
        end
    end

    // Clock config register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_config_reg <= tmz_ctl1_s'(`TMZ_RST_BYTE);
        end else if (wr_ctl1) begin
            clock_config_reg <= tmz_ctl1_s'(pwdata[7:0]);
        end
    end

    // Instruction clock enable, system clock over four
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_div <= 2'h0;
        end else begin
            instr_div <= instr_div + 2'h1;
        end
    end
    assign instr_en = (instr_div == `TMZ_INSTR_LAST);

    // Source select and edge detect
    tmz_clk_sel u_clk_sel (
        .pclk(pclk),
        .presetn(presetn),
        .src(src),
        .instr_en(instr_en),
        .sel(clock_config_reg.clock_source_select),
        .rise(src_rise)
    );

    // Writes to low or either control register restart both scalers
    assign scaler_clr = wr_low | wr_ctl0 | wr_ctl1; // [RULE13]

    // Input prescaler, held clear while disabled
    tmz_prescale u_prescale (
        .pclk(pclk),
        .presetn(presetn),
        .clr(scaler_clr | ~timer_enable_bit), // [RULE13]
        .sel(clock_config_reg.prescale_select),
        .in_pulse(src_rise),
        .out_pulse(pre_pulse)
    );

    // Sync mode holds an edge until the next instruction clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend <= 1'b0;
        end else if (scaler_clr || clock_config_reg.async_select_bit) begin
            pend <= 1'b0;
        end else if (pre_pulse && !instr_en) begin
            pend <= 1'b1; // A scaler clear or async mode wins over the set
        end else if (instr_en) begin
            pend <= 1'b0;
        end
    end

    // Count tick, bypassing the instruction clock in async mode
    always_comb begin
        if (!timer_enable_bit) begin
            cnt_tick = 1'b0; // [RULE4]
        end else if (clock_config_reg.async_select_bit) begin
            cnt_tick = pre_pulse; // [RULE8]
        end else begin
            cnt_tick = instr_en & (pend | pre_pulse); // [RULE8]
        end
    end

    assign period_hit = ~width_select_bit & (count_low_reg == period_buf);
    assign roll_hit = width_select_bit & (count_low_reg == 8'hFF) & (count_high == 8'hFF);
    assign tmr_event = cnt_tick & (period_hit | roll_hit);

    // Low counter; a bus write beats a tick in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_low_reg <= `TMZ_RST_BYTE;
        end else if (wr_low) begin
            count_low_reg <= pwdata[7:0]; // [RULE1]
        end else if (cnt_tick) begin
            if (period_hit) begin
                count_low_reg <= 8'h00; // [RULE2] [RULE10]
            end else begin
                count_low_reg <= count_low_reg + 8'h01; // [RULE1] [RULE5]
            end
        end
    end

    // High byte of the 16-bit count, loaded from the buffer on a low write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_high <= `TMZ_RST_BYTE;
        end else if (wr_low && width_select_bit) begin
            count_high <= period_high_reg; // [RULE14]
        end else if (cnt_tick && width_select_bit && count_low_reg == 8'hFF) begin
            count_high <= count_high + 8'h01; // [RULE3]
        end
    end

    // Period or high buffer; a low read snapshots the high byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_high_reg <= `TMZ_RST_BYTE;
        end else if (wr_high) begin
            period_high_reg <= pwdata[7:0]; // [RULE2]
        end else if (rd_low && width_select_bit) begin
            period_high_reg <= count_high; // [RULE14]
        end
    end

    // Compare copy, refreshed only on a match so a new period takes effect next round
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_buf <= `TMZ_RST_BYTE;
        end else if (cnt_tick && period_hit) begin
            period_buf <= period_high_reg; // [RULE10]
        end
    end

    assign post_hit = tmr_event & (post_cnt == postscale_select);

    // Output postscaler
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            post_cnt <= 4'h0;
        end else if (scaler_clr) begin
            post_cnt <= 4'h0; // [RULE13]
        end else if (post_hit) begin
            post_cnt <= 4'h0; // [RULE6]
        end else if (tmr_event) begin
            post_cnt <= post_cnt + 4'h1; // [RULE6]
        end
    end

    // Timer output toggle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_output <= 1'b0;
        end else if (post_hit && !scaler_clr) begin
            timer_output <= ~timer_output; // [RULE11]
        end
    end

    // Status register; a toggle beats a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_irq_flag <= 1'b0;
            timer_irq_enable <= 1'b0;
        end else begin
            if (post_hit && !scaler_clr) begin
                timer_irq_flag <= 1'b1; // [RULE12]
            end else if (wr_stat && pwdata[`TMZ_STAT_FLAG]) begin
                timer_irq_flag <= 1'b0; // Write one to clear
            end
            if (wr_stat) begin
                timer_irq_enable <= pwdata[`TMZ_STAT_IE];
            end
        end
    end

    // Interrupt request, one cycle behind the flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_irq <= 1'b0;
        end else begin
            timer_irq <= timer_irq_flag & timer_irq_enable; // [RULE12]
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_low_write_load: assert property (wr_low |=> count_low_reg == $past(pwdata[7:0])) // [RULE1]
        else $error("low count write lost");

    a_period_wrap: assert property (cnt_tick && period_hit && !wr_low && !wr_high
        |=> count_low_reg == 8'h00 && period_buf == $past(period_high_reg)) // [RULE2]
        else $error("period match did not wrap");

    a_high_carry: assert property (cnt_tick && width_select_bit && count_low_reg == 8'hFF && !wr_low
        |=> count_high == $past(count_high) + 8'h01) // [RULE3]
        else $error("high byte carry missing");

    a_disabled_hold: assert property (!timer_enable_bit && !wr_low |=> count_low_reg == $past(count_low_reg)) // [RULE4]
        else $error("disabled timer moved");

    a_wide_roll: assert property (cnt_tick && width_select_bit && count_low_reg == 8'hFF && count_high == 8'hFF
        && !wr_low |-> tmr_event ##1 (count_low_reg == 8'h00 && count_high == 8'h00)) // [RULE5]
        else $error("16-bit rollover missed");

    a_post_divide: assert property (tmr_event && !scaler_clr && post_cnt != postscale_select
        |=> post_cnt == $past(post_cnt) + 4'h1 && timer_output == $past(timer_output)) // [RULE6]
        else $error("postscaler ratio wrong");

    // A held edge must reach the counter at the next instruction clock
    a_sync_align: assert property (pre_pulse && timer_enable_bit && !clock_config_reg.async_select_bit && !scaler_clr
        |-> ##[0:3] ((cnt_tick && instr_en) || scaler_clr || !timer_enable_bit)) // [RULE8]
        else $error("sync tick off instruction clock");

    a_scaler_clear: assert property (scaler_clr |=> post_cnt == 4'h0 && !pend) // [RULE13]
        else $error("scaler not cleared");

    a_out_toggle: assert property (post_hit && !scaler_clr |=> timer_output != $past(timer_output)) // [RULE11]
        else $error("output did not toggle");

    a_flag_on_toggle: assert property (post_hit && !scaler_clr
        |=> timer_irq_flag ##1 timer_irq == $past(timer_irq_enable)) // [RULE12]
        else $error("flag or request missing");

    a_high_snapshot: assert property (rd_low && width_select_bit && !wr_high |=> period_high_reg == $past(count_high)) // [RULE14]
        else $error("high byte not latched");

    a_ctl0_read: assert property (rd && hit_ctl0
        |-> pready && prdata[6] == 1'b0 && prdata[5] == $past(timer_output)) // [RULE15]
        else $error("control read bits wrong");

    c_period_wrap: cover property (cnt_tick && period_hit && period_buf != 8'h00);
    c_wide_roll: cover property (cnt_tick && roll_hit);
    c_irq_raise: cover property (timer_irq_enable && post_hit ##2 timer_irq);
    c_async_tick: cover property (clock_config_reg.async_select_bit && cnt_tick && !instr_en);

endmodule // tmz_timer

// ===== tmz_timer_tb.sv
`timescale 1ns/1ps
`include "tmz_map.svh"

module testbench;
    import tmz_pkg::*;
    // Clock, reset and APB
    logic pclk, presetn, psel, penable, pwrite;
    logic [12:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr;
    // Counting sources and results
    tmz_src_s src;
    logic timer_output, timer_irq;
    // Bookkeeping
    int miscompares, checked, cyc, toggles, last_t;
    logic prev_out;

    tmz_timer tmz_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src(src), .timer_output(timer_output), .timer_irq(timer_irq));

    // 20 MHz clock
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // Cycle count and output toggle tracking
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        prev_out <= timer_output;
        // Ignore the unknown-to-reset settling before release
        if (presetn && timer_output !== prev_out) begin
            toggles <= toggles + 1;
            last_t <= cyc;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; the slave's wait states are not assumed
    task automatic apb(input logic wr, input logic [10:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, 1'b0, 1'b1);
        end
    endtask

    task automatic wr(input logic [10:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, {24'h0000_00, d}, r, e);
    endtask

    // Read and compare data and error response
    task automatic rdc(input logic [10:0] idx, input logic [7:0] ex, input logic ee);
        logic [31:0] r;
        logic e;
        apb(1'b0, idx, 32'h0000_0000, r, e);
        check(r, {24'h0000_00, ex});
        check({31'h0, e}, {31'h0, ee});
    endtask

    // Bounded wait for the next output toggle
    task automatic wait_tog();
        int n0;
        int n;
        n0 = toggles;
        n = 0;
        while (toggles == n0 && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        check(32'(toggles != n0), 32'h0000_0001);
    endtask

    task automatic t_reset();
        rdc(`TMZ_IDX_LOW, 8'h00, 1'b0);
        rdc(`TMZ_IDX_HIGH, 8'h00, 1'b0);
        rdc(`TMZ_IDX_CTL0, 8'h00, 1'b0);
        rdc(`TMZ_IDX_CTL1, 8'h00, 1'b0);
        rdc(`TMZ_IDX_STAT, 8'h00, 1'b0);
        rdc(11'h59B, 8'h00, 1'b1);
        $display("test reset done");
    endtask

    // Reserved and read-only bits ignore writes
    task automatic t_fields();
        wr(`TMZ_IDX_CTL0, 8'h7F);
        rdc(`TMZ_IDX_CTL0, 8'h1F, 1'b0);
        wr(`TMZ_IDX_CTL1, 8'hFF);
        rdc(`TMZ_IDX_CTL1, 8'hFF, 1'b0);
        wr(`TMZ_IDX_CTL0, 8'h00);
        $display("test fields done");
    endtask

    // Toggle interval from prescale, period and postscale
    task automatic t_rate();
        int ck[5] = '{0, 2, 0, 1, 3};
        int pe[5] = '{3, 1, 0, 2, 0};
        int op[5] = '{1, 0, 15, 2, 0};
        int t0;
        for (int i = 0; i < 5; i++) begin
            wr(`TMZ_IDX_CTL0, 8'h00);
            wr(`TMZ_IDX_CTL1, {3'h2, 1'(i % 2), 4'(ck[i])});
            wr(`TMZ_IDX_HIGH, 8'(pe[i]));
            wr(`TMZ_IDX_LOW, 8'h00);
            wr(`TMZ_IDX_CTL0, {4'h8, 4'(op[i])});
            wait_tog();
            wait_tog();
            t0 = last_t;
            wait_tog();
            check(32'(last_t - t0), 32'((4 << ck[i]) * (pe[i] + 1) * (op[i] + 1)));
        end
        $display("test rate done");
    endtask

    // Each external source counts its own rising edges
    task automatic t_src();
        int codes[7] = '{0, 1, 3, 4, 5, 6, 7};
        int bits[7] = '{5, 5, 4, 3, 2, 1, 0};
        int n0;
        for (int i = 0; i < 7; i++) begin
            wr(`TMZ_IDX_CTL0, 8'h00);
            src <= (codes[i] == 1) ? 6'h20 : 6'h00;
            wr(`TMZ_IDX_CTL1, {3'(codes[i]), 1'(i % 2), 4'h0});
            wr(`TMZ_IDX_HIGH, 8'h00);
            wr(`TMZ_IDX_CTL0, 8'h80);
            n0 = toggles;
            repeat (6) begin
                src[bits[i]] <= ~src[bits[i]];
                repeat (12) @(posedge pclk);
            end
            check(32'(toggles - n0), 32'h0000_0003);
        end
        $display("test sources done");
    endtask

    task automatic t_irq();
        wr(`TMZ_IDX_CTL0, 8'h00);
        rdc(`TMZ_IDX_CTL0, toggles[0] ? 8'h20 : 8'h00, 1'b0);
        rdc(`TMZ_IDX_STAT, 8'h01, 1'b0);
        check({31'h0, timer_irq}, 32'h0000_0000);
        wr(`TMZ_IDX_STAT, 8'h02);
        repeat (2) @(posedge pclk);
        check({31'h0, timer_irq}, 32'h0000_0001);
        wr(`TMZ_IDX_STAT, 8'h03);
        repeat (2) @(posedge pclk);
        check({31'h0, timer_irq}, 32'h0000_0000);
        rdc(`TMZ_IDX_STAT, 8'h02, 1'b0);
        wr(`TMZ_IDX_STAT, 8'h00);
        $display("test interrupt done");
    endtask

    // Disabled timer holds; scaler cleared by low writes
    task automatic t_hold();
        int n0;
        wr(`TMZ_IDX_CTL1, 8'h40);
        wr(`TMZ_IDX_LOW, 8'h05);
        n0 = toggles;
        repeat (40) @(posedge pclk);
        rdc(`TMZ_IDX_LOW, 8'h05, 1'b0);
        wr(`TMZ_IDX_CTL1, 8'h43);
        wr(`TMZ_IDX_HIGH, 8'h00);
        wr(`TMZ_IDX_CTL0, 8'h80);
        repeat (8) begin
            wr(`TMZ_IDX_LOW, 8'h00);
            repeat (12) @(posedge pclk);
        end
        check(32'(toggles - n0), 32'h0000_0000);
        $display("test hold done");
    endtask

    // 16-bit buffered access and rollover
    task automatic t_wide();
        logic [31:0] r;
        logic e;
        int n0;
        wr(`TMZ_IDX_CTL0, 8'h10);
        wr(`TMZ_IDX_HIGH, 8'h12);
        wr(`TMZ_IDX_LOW, 8'h34);
        rdc(`TMZ_IDX_LOW, 8'h34, 1'b0);
        rdc(`TMZ_IDX_HIGH, 8'h12, 1'b0);
        wr(`TMZ_IDX_CTL1, 8'h40);
        wr(`TMZ_IDX_HIGH, 8'hFF);
        wr(`TMZ_IDX_LOW, 8'hF0);
        wr(`TMZ_IDX_CTL0, 8'h90);
        n0 = toggles;
        repeat (40) @(posedge pclk);
        check(32'(toggles - n0), 32'h0000_0000);
        wait_tog();
        wr(`TMZ_IDX_CTL0, 8'h10);
        apb(1'b0, `TMZ_IDX_LOW, 32'h0000_0000, r, e);
        rdc(`TMZ_IDX_HIGH, 8'h00, 1'b0);
        $display("test wide done");
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        #(50 * 40000);
        miscompares++;
        finish_test();
    end

    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 13'h0000;
        pwdata = 32'h0000_0000;
        src = '0;
        prev_out = 1'b0;
        miscompares = 0;
        checked = 0;
        cyc = 0;
        toggles = 0;
        last_t = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_fields();
        t_rate();
        t_src();
        t_irq();
        t_hold();
        t_wide();
        finish_test();
    end
endmodule // testbench
